// ===== hw/rail_status_pkg.sv
package rail_status_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] GOOD_A_OFFSET = 8'hB0;
  localparam logic [7:0] GOOD_B_OFFSET = 8'hB1;
  localparam logic [7:0] FAULT_A_OFFSET = 8'hB2;
  localparam logic [7:0] FAULT_B_OFFSET = 8'hB3;

  // ----------------------------------------
  // Reset values and implemented-bit masks
  // ----------------------------------------
  localparam logic [7:0] GOOD_A_RESET = 8'h00;
  localparam logic [7:0] GOOD_B_RESET = 8'h00;
  localparam logic [7:0] FAULT_A_RESET = 8'h00;
  localparam logic [7:0] FAULT_B_RESET = 8'h00;
  localparam logic [7:0] BANK_A_MASK = 8'hBF;
  localparam logic [7:0] GOOD_B_MASK = 8'h39;
  localparam logic [7:0] FAULT_B_MASK = 8'h19;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int STEPDOWN_1_POS = 0;
  localparam int LINEAR_A2_POS = 7;
  localparam int LINEAR_A3_POS = 0;
  localparam int TERMINATION_POS = 3;
  localparam int LINEAR_A1_POS = 4;
  localparam int FIVE_VOLT_POS = 5;

  // ----------------------------------------
  // Input synchroniser depth
  // ----------------------------------------
  localparam int SYNC_STAGES = 3;

  // Per-rail regulation levels
  typedef struct packed {
    logic [5:0] stepdown_rail;
    logic linear_rail_a1;
    logic linear_rail_a2;
    logic linear_rail_a3;
    logic five_volt_linear_rail;
    logic termination_rail;
  } rail_levels_s;

  // Register access from the serial engine
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_s;

  localparam int RAIL_COUNT = 11;

endpackage

// ===== hw/pin_sync.sv
`timescale 1ns/10ps
module pin_sync
  import rail_status_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic async_in,
  output logic level_out
);

  logic [SYNC_STAGES-1:0] stage_reg;
  logic [SYNC_STAGES-1:0] stage_next;
  logic level_reg;
  logic level_next;

  // Accept a change once the last two stages agree
  always_comb begin
    stage_next = {stage_reg[SYNC_STAGES-2:0], async_in};
    level_next = level_reg;
    if (stage_reg[SYNC_STAGES-1] == stage_reg[SYNC_STAGES-2]) begin
      level_next = stage_reg[SYNC_STAGES-1];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_reg <= '0;
      level_reg <= 1'b0;
    end else begin
      stage_reg <= stage_next;
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;

endmodule

// ===== hw/fault_latch.sv
`timescale 1ns/10ps
module fault_latch (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic good,
  input wire logic clear,
  output logic flag
);

  logic flag_reg;
  logic flag_next;
  logic good_reg;
  logic good_next;

  // Loss of regulation is the falling edge of good; set wins over clear
  always_comb begin
    good_next = good;
    flag_next = flag_reg;
    if (clear) begin
      flag_next = 1'b0;
    end
    if (good_reg && !good) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_reg <= 1'b0;
      good_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      good_reg <= good_next;
    end
  end

  assign flag = flag_reg;

endmodule

// ===== hw/rail_good_and_fault_status.sv
`timescale 1ns/10ps
// Summary of operation
// - Good bit is 1 while rail is in regulation; linear A2 at bit 7.
// - First good register: step-down rails 1..6 on bits 0..5, bit 6 reserved.
// - Second good register: five-volt bit 5, A1 bit 4, termination 3, A3 0.
// - Good registers are read-only, reset to zero, writes ignored.
// - Fault flag sets on loss of regulation and stays until cleared.
// - Writing 1 clears a fault flag; writing 0 leaves it.
// - First fault register: A2 at bit 7, step-down 6..1 at bits 5..0.
// - Fault registers at B2h and B3h, reset to zero.
// - Second fault register: A1 bit 4, termination bit 3, A3 bit 0.
module rail_good_and_fault_status
  import rail_status_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_B,
  input wire rail_levels_s RAIL_GOOD,
  input wire reg_access_s REG_ACCESS,
  output logic [7:0] RDATA,
  output logic RDATA_VALID
);

  // ----------------------------------------
  // Rail level synchronisers
  // ----------------------------------------
  logic [RAIL_COUNT-1:0] raw_good;
  logic [RAIL_COUNT-1:0] sync_good;

  assign raw_good = RAIL_GOOD;

  genvar i;
  generate
    for (i = 0; i < RAIL_COUNT; i++) begin : g_sync
      pin_sync u_sync (
        .clk(MCLK),
        .rst_b(RST_B),
        .async_in(raw_good[i]),
        .level_out(sync_good[i])
      );
    end
  endgenerate

  rail_levels_s good_s;
  assign good_s = sync_good;

  // ----------------------------------------
  // Power-good views
  // ----------------------------------------
  logic [7:0] good_a;
  logic [7:0] good_b;

  always_comb begin
    good_a = GOOD_A_RESET;
    good_a[LINEAR_A2_POS] = good_s.linear_rail_a2;
    good_a[STEPDOWN_1_POS +: 6] = good_s.stepdown_rail;
    good_b = GOOD_B_RESET;
    good_b[FIVE_VOLT_POS] = good_s.five_volt_linear_rail;
    good_b[LINEAR_A1_POS] = good_s.linear_rail_a1;
    good_b[TERMINATION_POS] = good_s.termination_rail;
    good_b[LINEAR_A3_POS] = good_s.linear_rail_a3;
  end

  // ----------------------------------------
  // Fault latches
  // ----------------------------------------
  logic [7:0] clear_a;
  logic [7:0] clear_b;
  logic [7:0] fault_a;
  logic [7:0] fault_b;
  logic [7:0] good_a_masked;
  logic [7:0] good_b_masked;

  always_comb begin
    clear_a = 8'h00;
    clear_b = 8'h00;
    if (REG_ACCESS.wr_en && REG_ACCESS.addr == FAULT_A_OFFSET) begin
      clear_a = REG_ACCESS.wdata & BANK_A_MASK;
    end
    if (REG_ACCESS.wr_en && REG_ACCESS.addr == FAULT_B_OFFSET) begin
      clear_b = REG_ACCESS.wdata & FAULT_B_MASK;
    end
  end

  // Bit positions of the fault registers follow the good registers
  assign good_a_masked = good_a;
  assign good_b_masked = good_b;

  generate
    for (i = 0; i < 8; i++) begin : g_fault
      if (BANK_A_MASK[i]) begin : g_a
        fault_latch u_fa (
          .clk(MCLK),
          .rst_b(RST_B),
          .good(good_a_masked[i]),
          .clear(clear_a[i]),
          .flag(fault_a[i])
        );
      end else begin : g_a_res
        assign fault_a[i] = 1'b0;
      end
      if (FAULT_B_MASK[i]) begin : g_b
        fault_latch u_fb (
          .clk(MCLK),
          .rst_b(RST_B),
          .good(good_b_masked[i]),
          .clear(clear_b[i]),
          .flag(fault_b[i])
        );
      end else begin : g_b_res
        assign fault_b[i] = 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic valid_reg;
  logic valid_next;

  // Writes to the good registers have no path to any state
  always_comb begin
    rdata_next = rdata_reg;
    valid_next = REG_ACCESS.rd_en;
    if (REG_ACCESS.rd_en) begin
      case (REG_ACCESS.addr)
        GOOD_A_OFFSET: rdata_next = good_a & BANK_A_MASK;
        GOOD_B_OFFSET: rdata_next = good_b & GOOD_B_MASK;
        FAULT_A_OFFSET: rdata_next = fault_a;
        FAULT_B_OFFSET: rdata_next = fault_b;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_reg <= 8'h00;
      valid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      valid_reg <= valid_next;
    end
  end

  assign RDATA = rdata_reg;
  assign RDATA_VALID = valid_reg;

endmodule

// ===== test/rail_host_model.sv
`timescale 1ns/10ps
module rail_host_model
  import rail_status_pkg::*;
(
  input wire logic mclk,
  input wire logic [7:0] rdata,
  input wire logic rdata_valid,
  output reg_access_s acc
);
  initial acc = '{1'b0, 1'b0, 8'h00, 8'h00};
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1 acc = '{w, ~w, a, d};
    @(posedge mclk);
    // Released lines show junk
    #1 acc = '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd_op(input logic [7:0] a, output logic [7:0] d, output logic v);
    put(1'b0, a, 8'h00);
    d = rdata;
    v = rdata_valid;
  endtask
  task automatic wr_op(input logic [7:0] a, input logic [7:0] d);
    put(1'b1, a, d);
  endtask
endmodule

// ===== test/rail_good_and_fault_status_assertions.sv
`timescale 1ns/10ps
module rail_good_and_fault_status_assertions
  import rail_status_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_B,
  input wire rail_levels_s RAIL_GOOD,
  input wire reg_access_s REG_ACCESS,
  input wire logic [7:0] RDATA,
  input wire logic RDATA_VALID
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  chk_read_answered: assert property (REG_ACCESS.rd_en |=> RDATA_VALID)
    else $error("read not answered");
  chk_valid_cause: assert property (RDATA_VALID |-> $past(REG_ACCESS.rd_en))
    else $error("answer without read");
  chk_rdata_hold: assert property (!RDATA_VALID |-> $stable(RDATA))
    else $error("read data moved");
  chk_rsvd_bank_a: assert property (RDATA_VALID && ($past(REG_ACCESS.addr) == GOOD_A_OFFSET
    || $past(REG_ACCESS.addr) == FAULT_A_OFFSET)
    |-> (RDATA & ~BANK_A_MASK) == 8'h00) else $error("bank a reserved bit set");
  chk_rsvd_good_b: assert property (RDATA_VALID && $past(REG_ACCESS.addr) == 8'hB1
    |-> (RDATA & ~GOOD_B_MASK) == 8'h00) else $error("good b reserved bit set");
  chk_rsvd_fault_b: assert property (RDATA_VALID && $past(REG_ACCESS.addr) == 8'hB3
    |-> (RDATA & ~FAULT_B_MASK) == 8'h00) else $error("fault b reserved bit set");
  chk_unmapped_zero: assert property (RDATA_VALID && $past(REG_ACCESS.addr[7:2]) != 6'h2C
    |-> RDATA == 8'h00) else $error("unmapped read not zero");
  chk_reset_quiet: assert property ($rose(RST_B) |-> RDATA == 8'h00 && !RDATA_VALID)
    else $error("outputs not clear after reset");
endmodule
bind rail_good_and_fault_status rail_good_and_fault_status_assertions
  rail_good_and_fault_status_assertions_inst (.MCLK(MCLK), .RST_B(RST_B),
  .RAIL_GOOD(RAIL_GOOD), .REG_ACCESS(REG_ACCESS), .RDATA(RDATA), .RDATA_VALID(RDATA_VALID));

// ===== test/tb_rail_good_and_fault_status.sv
`timescale 1ns/10ps
module tb_rail_good_and_fault_status
  import rail_status_pkg::*;
;
  logic MCLK = 1'b0;
  logic RST_B = 1'b0;
  rail_levels_s RAIL_GOOD = '0;
  reg_access_s acc;
  logic [7:0] RDATA;
  logic RDATA_VALID;
  int err_total = 0;
  int num_checks = 0;
  initial begin
    forever #10 MCLK = ~MCLK;
  end
  rail_good_and_fault_status rail_good_and_fault_status_inst (.MCLK(MCLK), .RST_B(RST_B),
    .RAIL_GOOD(RAIL_GOOD), .REG_ACCESS(acc), .RDATA(RDATA), .RDATA_VALID(RDATA_VALID));
  rail_host_model rail_host_model_inst (.mclk(MCLK), .rdata(RDATA),
    .rdata_valid(RDATA_VALID), .acc(acc));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    rail_host_model_inst.rd_op(a, d, v);
    chk({7'h00, v}, 8'h01);
    chk(d, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    rail_host_model_inst.wr_op(a, d);
  endtask
  task automatic settle(input logic [10:0] r);
    @(posedge MCLK);
    #1 RAIL_GOOD = rail_levels_s'(r);
    repeat (8) @(posedge MCLK);
  endtask
  task automatic t_reset;
    rd(GOOD_A_OFFSET, GOOD_A_RESET);
    rd(GOOD_B_OFFSET, GOOD_B_RESET);
    rd(FAULT_A_OFFSET, FAULT_A_RESET);
    rd(FAULT_B_OFFSET, FAULT_B_RESET);
    rd(8'hB4, 8'h00);
    $display("test reset values done");
  endtask
  task automatic t_good;
    settle(11'h7FF);
    rd(GOOD_A_OFFSET, 8'hBF);
    rd(GOOD_B_OFFSET, 8'h39);
    wr(GOOD_A_OFFSET, 8'h00);
    wr(GOOD_B_OFFSET, 8'h00);
    rd(GOOD_A_OFFSET, 8'hBF);
    rd(GOOD_B_OFFSET, 8'h39);
    settle(11'h414);
    rd(GOOD_A_OFFSET, 8'h20);
    rd(GOOD_B_OFFSET, 8'h11);
    $display("test good bits done");
  endtask
  task automatic t_fault;
    settle(11'h000);
    settle(11'h7FF);
    rd(FAULT_A_OFFSET, 8'hBF);
    rd(FAULT_B_OFFSET, 8'h19);
    wr(FAULT_A_OFFSET, 8'h01);
    rd(FAULT_A_OFFSET, 8'hBE);
    wr(FAULT_A_OFFSET, 8'h00);
    rd(FAULT_A_OFFSET, 8'hBE);
    wr(FAULT_B_OFFSET, 8'hFF);
    rd(FAULT_B_OFFSET, 8'h00);
    wr(FAULT_A_OFFSET, 8'hFF);
    rd(FAULT_A_OFFSET, 8'h00);
    $display("test fault flags done");
  endtask
  task automatic t_collide;
    @(posedge MCLK);
    #1 RAIL_GOOD = rail_levels_s'(11'h7DF);
    // Clear lands in the cycle the synchronised fall sets the flag
    repeat (3) @(posedge MCLK);
    wr(FAULT_A_OFFSET, 8'h01);
    rd(FAULT_A_OFFSET, 8'h01);
    wr(FAULT_A_OFFSET, 8'h01);
    rd(FAULT_A_OFFSET, 8'h00);
    settle(11'h7FF);
    rd(FAULT_A_OFFSET, 8'h00);
    $display("test set beats clear done");
  endtask
  task automatic t_mid_reset;
    settle(11'h000);
    settle(11'h7FF);
    rd(FAULT_B_OFFSET, 8'h19);
    @(posedge MCLK);
    #1 RST_B = 1'b0;
    repeat (2) @(posedge MCLK);
    #1 RST_B = 1'b1;
    rd(GOOD_A_OFFSET, GOOD_A_RESET);
    rd(FAULT_A_OFFSET, FAULT_A_RESET);
    rd(FAULT_B_OFFSET, FAULT_B_RESET);
    settle(11'h7FF);
    rd(GOOD_A_OFFSET, 8'hBF);
    rd(FAULT_A_OFFSET, 8'h00);
    $display("test mid-run reset done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge MCLK);
    #1 RST_B = 1'b1;
    t_reset;
    t_good;
    t_fault;
    t_collide;
    t_mid_reset;
    tally_and_finish;
  end
  initial begin
    repeat (3000) @(posedge MCLK);
    err_total++;
    tally_and_finish;
  end
endmodule
